// file: p1gp_map.vh
/*
  Address map, reset values and mux codes for the port 1 GPIO block.
  Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
*/
`ifndef P1GP_MAP_VH
`define P1GP_MAP_VH

// Width of the byte address seen by the slave.
`define P1GP_ADDR_W 4
// Byte offsets of the three port registers.
`define P1GP_OFS_DIR 4'h0
`define P1GP_OFS_DATA 4'h4
`define P1GP_OFS_STATE 4'h8
// Word index of each register, taken from byte address bits 3:2.
`define P1GP_IDX_DIR 2'h0
`define P1GP_IDX_DATA 2'h1
`define P1GP_IDX_STATE 2'h2
`define P1GP_IDX_SPARE 2'h3
// Reset values of the writable registers.
`define P1GP_DIR_RST 8'h00
`define P1GP_DATA_RST 8'h00
// Value returned when the write-only direction register is read.
`define P1GP_DIR_READ 8'h00
// Output enables are active low, so all ones means every pin floats.
`define P1GP_OE_N_RST 8'hff
// Upper bits of the read word that carry no data.
`define P1GP_PAD_ZERO 24'h000000
// AXI response codes.
`define P1GP_RESP_OKAY 2'h0
`define P1GP_RESP_SLVERR 2'h2
// Prescaler select codes that route a pin to an external timer clock.
`define P1GP_PSC_CLKD 3'h7
`define P1GP_PSC_CLKC_LO 3'h6
`define P1GP_PSC_CLKC_HI 3'h5
// Upper two I/O control bits that mark capture input on channel 1 B.
`define P1GP_IOC_CAPTURE 2'h2
// Bit positions of the multiplexed pins.
`define P1GP_BIT_CLKD 7
`define P1GP_BIT_CAPA 6
`define P1GP_BIT_CLKC 5

`endif

// file: p1gp_pin_sync.v
/*
  Three-stage synchroniser with agreement filter for a group of pins.
  Assumes the inputs are asynchronous to aclk and the reset is synchronous.
*/
`timescale 1ns/1ps

module p1gp_pin_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset.
  input  wire             aclk,
  input  wire             aresetn,
  // Raw pin levels and their filtered image.
  input  wire [WIDTH-1:0] raw_in,
  output wire [WIDTH-1:0] level
);

  reg [WIDTH-1:0] s1_q;   // First stage, read only by the second.
  reg [WIDTH-1:0] s2_q;   // Second stage.
  reg [WIDTH-1:0] s3_q;   // Third stage.
  reg [WIDTH-1:0] lvl_q;  // Accepted level.

  // Shift the pins in, and accept a bit once stages two and three agree.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q  <= {WIDTH{1'b0}};
      s2_q  <= {WIDTH{1'b0}};
      s3_q  <= {WIDTH{1'b0}};
      lvl_q <= {WIDTH{1'b0}};
    end else begin
      s1_q  <= raw_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end
  end

  assign level = lvl_q;

endmodule

// file: p1gp_port.v
/*
  Port 1 general purpose I/O with pulse timer pin multiplexing on bits 7..5.
  Registers are reached over AXI4-Lite; the pins face the board and the
  timer unit supplies its modes, I/O control and prescaler selects.
  Assumes one clock (aclk) and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "p1gp_map.vh"

// Summary of operation
// - Eight pins, each with direction, data, state bits.
// - Direction one drives output, zero makes input.
// - Direction register is write-only; reads return 00.
// - Data register is read/write output value.
// - State read: data where output, pin where input.
// - State register ignores writes completely.
// - Timer output enable overrides the direction bit.
// - Bit 7 muxed by channel 2, prescalers, direction.
// - Bit 7 feeds channel 2 capture B.
// - Bit 7 feeds external clock D.
// - Bit 6 feeds channel 2 capture A.
// - Bit 5 feeds channel 1 capture B on 10xx.
// - Bit 5 feeds external clock C.
module p1gp_port (
  // Clock and reset.
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address channel.
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data channel.
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response channel.
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address channel.
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data channel.
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // Board pins, split into input, output and active-low output enable.
  input  wire [7:0]  pin_in,
  output wire [7:0]  pin_out,
  output wire [7:0]  pin_oe_n,
  // Timer output drive for bits 7..5 (capture B2, capture A2, capture B1).
  input  wire [2:0]  tmr_pin_oe,
  input  wire [2:0]  tmr_pin_out,
  // Timer channel operating modes.
  input  wire        tmr1_mode_normal,
  input  wire        tmr1_mode_phase,
  input  wire        tmr2_mode_normal,
  input  wire        tmr2_mode_phase,
  input  wire        tmr4_mode_phase,
  // Timer I/O control bits.
  input  wire        io_ctrl_b_bit3,
  input  wire        io_ctrl_a_bit3,
  input  wire [3:0]  timer1_io_control_b,
  // Prescaler select fields of timer channels 0, 2, 4 and 5.
  input  wire [2:0]  prescaler_select0,
  input  wire [2:0]  prescaler_select2,
  input  wire [2:0]  prescaler_select4,
  input  wire [2:0]  prescaler_select5,
  // Pin-derived inputs for the timer and interrupt controller.
  output wire        timer2_capture_b,
  output wire        timer2_capture_a,
  output wire        timer1_capture_b,
  output wire        ext_timer_clock_d,
  output wire        ext_timer_clock_c,
  output wire        ext_interrupt_1
);

  // Register state.
  reg  [7:0]  port_direction_q;    // Direction bits, one means output.
  reg  [7:0]  port_output_data_q;  // Output data bits.

  // Write channel holding state.
  reg         aw_full_q;           // Write address taken, not yet used.
  reg  [3:0]  aw_addr_q;           // Held write address.
  reg         w_full_q;            // Write data taken, not yet used.
  reg  [31:0] w_data_q;            // Held write data.
  reg  [3:0]  w_strb_q;            // Held write strobes.
  reg         bvalid_q;            // Write response pending.
  reg  [1:0]  bresp_q;             // Write response code.

  // Read channel state.
  reg         rvalid_q;            // Read data pending.
  reg  [31:0] rdata_q;             // Read data word.
  reg  [1:0]  rresp_q;             // Read response code.

  // Registered pin drive and timer-side inputs.
  reg  [7:0]  pin_out_q;           // Level driven onto each pin.
  reg  [7:0]  pin_oe_n_q;          // Active-low drive enable.
  reg  [5:0]  tmr_in_q;            // Gated pin levels toward the timer.

  // Combinational helpers.
  wire [7:0]  pin_level;           // Synchronised pin levels.
  wire [7:0]  tmr_drive;           // Pins currently driven by the timer.
  wire [7:0]  tmr_value;           // Timer output level per pin.
  wire [7:0]  pin_state;           // Value seen through the state register.
  wire        do_write;            // Both write halves are held.
  wire        cap2b_sel;           // Bit 7 routed to capture B2.
  wire        clkd_sel;            // Bit 7 routed to clock D.
  wire        cap2a_sel;           // Bit 6 routed to capture A2.
  wire        cap1b_sel;           // Bit 5 routed to capture B1.
  wire        clkc_sel;            // Bit 5 routed to clock C.
  reg  [31:0] rd_word;             // Decoded read word.
  reg  [1:0]  rd_resp;             // Decoded read response.

  // Bring the board pins into the clock domain.
  p1gp_pin_sync #(
    .WIDTH (8)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .raw_in  (pin_in),
    .level   (pin_level)
  );

  // The timer reaches only the upper three pins; the rest are plain GPIO.
  assign tmr_drive = {tmr_pin_oe, 5'h00};
  assign tmr_value = {tmr_pin_out, 5'h00};

  // Output pins read back their data bit, input pins their level.
  assign pin_state = (port_direction_q & port_output_data_q) |
                     (~port_direction_q & pin_level);

  // Function selects for the multiplexed upper pins.
  assign cap2b_sel = (tmr2_mode_normal | tmr2_mode_phase) & io_ctrl_b_bit3;
  assign cap2a_sel = (tmr2_mode_normal | tmr2_mode_phase) & io_ctrl_a_bit3;
  assign cap1b_sel = (tmr1_mode_normal | tmr1_mode_phase) &
                     (timer1_io_control_b[3:2] == `P1GP_IOC_CAPTURE);
  assign clkd_sel  = (prescaler_select0 == `P1GP_PSC_CLKD) |
                     (prescaler_select5 == `P1GP_PSC_CLKD) |
                     tmr2_mode_phase | tmr4_mode_phase;
  assign clkc_sel  = (prescaler_select0 == `P1GP_PSC_CLKC_LO) |
                     (prescaler_select2 == `P1GP_PSC_CLKC_LO) |
                     (prescaler_select4 == `P1GP_PSC_CLKC_HI) |
                     (prescaler_select5 == `P1GP_PSC_CLKC_HI) |
                     tmr2_mode_phase | tmr4_mode_phase;

  // A write is carried out once address and data are both held.
  assign do_write = aw_full_q & w_full_q & ~bvalid_q;

  // Channel handshakes: each half is taken while its holding slot is free; write halves also wait out a pending response.
  assign s_axi_awready = ~aw_full_q & ~bvalid_q;
  assign s_axi_wready  = ~w_full_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Pin-facing outputs come straight from flip-flops.
  assign pin_out  = pin_out_q;
  assign pin_oe_n = pin_oe_n_q;
  assign timer2_capture_b  = tmr_in_q[0];
  assign ext_timer_clock_d = tmr_in_q[1];
  assign timer2_capture_a  = tmr_in_q[2];
  assign ext_interrupt_1   = tmr_in_q[3];
  assign timer1_capture_b  = tmr_in_q[4];
  assign ext_timer_clock_c = tmr_in_q[5];

  // Hold the write address until the matching data has also arrived.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      // Address taken; keep it for the coming write.
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      // Address consumed by the register write.
      aw_full_q <= 1'b0;
    end
  end

  // Hold the write data and strobes until the address has also arrived.
  always @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      // Data taken; keep it for the coming write.
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      // Data consumed by the register write.
      w_full_q <= 1'b0;
    end
  end

  // Register writes; only byte lane 0 carries data, so only strobe 0 counts.
  always @(posedge aclk) begin
    if (!aresetn) begin
      port_direction_q   <= `P1GP_DIR_RST;
      port_output_data_q <= `P1GP_DATA_RST;
    end else if (do_write && w_strb_q[0]) begin
      case (aw_addr_q[3:2])
        // Direction register, one bit per pin.
        `P1GP_IDX_DIR: begin
          port_direction_q <= w_data_q[7:0];
        end
        // Output data register.
        `P1GP_IDX_DATA: begin
          port_output_data_q <= w_data_q[7:0];
        end
        // The state register and unmapped words keep nothing.
        default: begin
          port_direction_q <= port_direction_q;
        end
      endcase
    end
  end

  // Write response: raised after the write, held until the master takes it.
  always @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `P1GP_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      // The state register accepts a write silently; the spare word refuses.
      if (aw_addr_q[3:2] == `P1GP_IDX_SPARE) begin
        bresp_q <= `P1GP_RESP_SLVERR;
      end else begin
        bresp_q <= `P1GP_RESP_OKAY;
      end
    end else if (s_axi_bready) begin
      // Response delivered.
      bvalid_q <= 1'b0;
    end
  end

  // Read decode; the direction register never shows its stored bits.
  always @* begin
    rd_word = 32'h00000000;
    rd_resp = `P1GP_RESP_OKAY;
    case (s_axi_araddr[3:2])
      // Direction register reads a fixed filler value.
      `P1GP_IDX_DIR: begin
        rd_word = {`P1GP_PAD_ZERO, `P1GP_DIR_READ};
      end
      // Output data register reads back as stored.
      `P1GP_IDX_DATA: begin
        rd_word = {`P1GP_PAD_ZERO, port_output_data_q};
      end
      // Pin state register.
      `P1GP_IDX_STATE: begin
        rd_word = {`P1GP_PAD_ZERO, pin_state};
      end
      // Unmapped word.
      default: begin
        rd_resp = `P1GP_RESP_SLVERR;
      end
    endcase
  end

  // Read response: data captured when the address is taken.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= `P1GP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_resp;
    end else if (s_axi_rready) begin
      // Data delivered.
      rvalid_q <= 1'b0;
    end
  end

  // Pin drive: a timer output wins, otherwise the direction bit decides.
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_q  <= `P1GP_DATA_RST;
      pin_oe_n_q <= `P1GP_OE_N_RST;
    end else begin
      pin_out_q  <= (tmr_drive & tmr_value) |
                    (~tmr_drive & port_output_data_q);
      pin_oe_n_q <= ~(tmr_drive | port_direction_q);
    end
  end

  // Timer-side inputs follow the pin while selected, unless the timer drives that pin.
  // The interrupt line has no select; software keeps other outputs off it.
  always @(posedge aclk) begin
    if (!aresetn) begin
      tmr_in_q <= 6'h00;
    end else begin
      tmr_in_q[0] <= cap2b_sel & ~tmr_drive[`P1GP_BIT_CLKD] &
                     pin_level[`P1GP_BIT_CLKD];
      tmr_in_q[1] <= clkd_sel & ~tmr_drive[`P1GP_BIT_CLKD] &
                     pin_level[`P1GP_BIT_CLKD];
      tmr_in_q[2] <= cap2a_sel & ~tmr_drive[`P1GP_BIT_CAPA] &
                     pin_level[`P1GP_BIT_CAPA];
      tmr_in_q[3] <= ~tmr_drive[`P1GP_BIT_CAPA] &
                     pin_level[`P1GP_BIT_CAPA];
      tmr_in_q[4] <= cap1b_sel & ~tmr_drive[`P1GP_BIT_CLKC] &
                     pin_level[`P1GP_BIT_CLKC];
      tmr_in_q[5] <= clkc_sel & ~tmr_drive[`P1GP_BIT_CLKC] &
                     pin_level[`P1GP_BIT_CLKC];
    end
  end

endmodule

// file: p1gp_board.sv
/* Board-side model of the port 1 pins.
   Assumes the device drives a pin while its active-low enable is low. */
`timescale 1ns/1ps
module p1gp_board (
  // Device drive and the board's own level.
  input  wire [7:0] pin_out,
  input  wire [7:0] pin_oe_n,
  input  wire [7:0] ext_level,
  // Resolved level seen by the device.
  output wire [7:0] pin_in
);
  // A driven line carries the device level, so a pin read back shows what the port drives.
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule

// file: p1gp_port_props.sv
/* Port-level checks of the port 1 GPIO block.
   Assumes binding to p1gp_port, one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module p1gp_props (
  // Clock, reset and bus handshakes.
  input wire        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire        s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // Pins and timer side.
  input wire [7:0]  pin_in, pin_out, pin_oe_n,
  input wire [2:0]  tmr_pin_oe, tmr_pin_out, prescaler_select0, prescaler_select2,
  input wire [2:0]  prescaler_select4, prescaler_select5,
  input wire [3:0]  timer1_io_control_b,
  input wire        tmr2_mode_phase, tmr4_mode_phase, io_ctrl_b_bit3,
  input wire        timer2_capture_b, timer2_capture_a, timer1_capture_b,
  input wire        ext_timer_clock_d, ext_timer_clock_c, ext_interrupt_1
);
  // All checks sample on the rising edge; all but the reset check stand aside during reset.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write halves taken at one edge.
  sequence s_wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  // Interrupt pin left alone by the timer and steady long enough to pass the filter.
  sequence s_pin6_quiet; (!tmr_pin_oe[1] && $stable(pin_in[6])) [*7]; endsequence
  property p_rst_clear; disable iff (1'b0) !aresetn |=> pin_oe_n == 8'hff && pin_out == 8'h00 && !ext_interrupt_1; endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("pins not cleared by reset");
  property p_wr_resp; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read data late");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_tmr_drive; tmr_pin_oe == 3'h7 |=> pin_oe_n[7:5] == 3'h0 && pin_out[7:5] == $past(tmr_pin_out); endproperty
  a_tmr_drive: assert property (p_tmr_drive) else $error("timer drive lost");
  property p_pin_block6; tmr_pin_oe[1] |=> !ext_interrupt_1 && !timer2_capture_a; endproperty
  a_pin_block6: assert property (p_pin_block6) else $error("pin 6 input while timer drives");
  property p_pin_block5; tmr_pin_oe[0] |=> !timer1_capture_b && !ext_timer_clock_c; endproperty
  a_pin_block5: assert property (p_pin_block5) else $error("pin 5 input while timer drives");
  property p_clkd_off; prescaler_select0 != 3'h7 && prescaler_select5 != 3'h7 && !tmr2_mode_phase
    && !tmr4_mode_phase |=> !ext_timer_clock_d; endproperty
  a_clkd_off: assert property (p_clkd_off) else $error("clock d without select");
  property p_clkc_off; prescaler_select0 != 3'h6 && prescaler_select2 != 3'h6 && prescaler_select4 != 3'h5
    && prescaler_select5 != 3'h5 && !tmr2_mode_phase && !tmr4_mode_phase |=> !ext_timer_clock_c; endproperty
  a_clkc_off: assert property (p_clkc_off) else $error("clock c without select");
  property p_capb1_off; timer1_io_control_b[3:2] != 2'h2 |=> !timer1_capture_b; endproperty
  a_capb1_off: assert property (p_capb1_off) else $error("capture b1 without select");
  property p_capb2_off; !io_ctrl_b_bit3 |=> !timer2_capture_b; endproperty
  a_capb2_off: assert property (p_capb2_off) else $error("capture b2 without select");
  property p_irq_follow; s_pin6_quiet |-> ext_interrupt_1 == pin_in[6]; endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("interrupt input not following pin");
endmodule
bind p1gp_port p1gp_props u_p1gp_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .pin_in, .pin_out, .pin_oe_n, .tmr_pin_oe, .tmr_pin_out, .prescaler_select0, .prescaler_select2,
  .prescaler_select4, .prescaler_select5, .timer1_io_control_b, .tmr2_mode_phase, .tmr4_mode_phase,
  .io_ctrl_b_bit3, .timer2_capture_b, .timer2_capture_a, .timer1_capture_b, .ext_timer_clock_d,
  .ext_timer_clock_c, .ext_interrupt_1);

// file: p1gp_port_tb.sv
/* Self-checking bench for the port 1 GPIO block.
   Assumes the board model and the bound checker are compiled before it. */
`timescale 1ns/1ps
module p1gp_port_tb;
  // Bus and board stimulus, all driven at the rising edge.
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [2:0] tmr_pin_oe = 3'h0, tmr_pin_out = 3'h0;
  logic [7:0] ext_level = 8'h00;
  logic [22:0] cfg = 23'h0; // Timer modes, I/O control and prescaler selects in one word.
  wire tmr1_mode_normal, tmr1_mode_phase, tmr2_mode_normal, tmr2_mode_phase, tmr4_mode_phase;
  wire io_ctrl_b_bit3, io_ctrl_a_bit3;
  wire [3:0] timer1_io_control_b;
  wire [2:0] prescaler_select0, prescaler_select2, prescaler_select4, prescaler_select5;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] pin_in, pin_out, pin_oe_n;
  wire timer2_capture_b, timer2_capture_a, timer1_capture_b, ext_timer_clock_d, ext_timer_clock_c, ext_interrupt_1;
  wire [5:0] tin = {timer2_capture_b, timer2_capture_a, timer1_capture_b, ext_timer_clock_d, ext_timer_clock_c,
                    ext_interrupt_1};
  int errors = 0, n_compared = 0, cycles = 0, i;
  // Mux table: modes, I/O control, prescalers, then expected timer-side inputs with pins 7..5 high.
  logic [28:0] tbl [16] = '{{7'h00, 16'h0, 6'h01}, {7'h12, 16'h0, 6'h21}, {7'h11, 16'h0, 6'h11},
    {7'h0b, 16'h0, 6'h37}, {7'h04, 16'h0, 6'h07}, {7'h40, 16'hb000, 6'h09}, {7'h40, 16'h4000, 6'h01},
    {7'h20, 16'h8000, 6'h09}, {7'h00, 16'h0e00, 6'h05}, {7'h00, 16'h0007, 6'h05}, {7'h00, 16'h0c00, 6'h03},
    {7'h00, 16'h0180, 6'h03}, {7'h00, 16'h0028, 6'h03}, {7'h00, 16'h0005, 6'h03}, {7'h00, 16'h0bfe, 6'h01},
    {7'h02, 16'h0, 6'h01}};
  assign {tmr1_mode_normal, tmr1_mode_phase, tmr2_mode_normal, tmr2_mode_phase, tmr4_mode_phase, io_ctrl_b_bit3,
          io_ctrl_a_bit3, timer1_io_control_b, prescaler_select0, prescaler_select2, prescaler_select4,
          prescaler_select5} = cfg;
  p1gp_port u_p1gp_port (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out,
    .pin_oe_n, .tmr_pin_oe, .tmr_pin_out, .tmr1_mode_normal, .tmr1_mode_phase, .tmr2_mode_normal,
    .tmr2_mode_phase, .tmr4_mode_phase, .io_ctrl_b_bit3, .io_ctrl_a_bit3, .timer1_io_control_b,
    .prescaler_select0, .prescaler_select2, .prescaler_select4, .prescaler_select5, .timer2_capture_b,
    .timer2_capture_a, .timer1_capture_b, .ext_timer_clock_d, .ext_timer_clock_c, .ext_interrupt_1);
  p1gp_board u_p1gp_board (.pin_out, .pin_oe_n, .ext_level, .pin_in);
  // Compares one value, counting it and any mismatch.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Waits n edges, then settles at the falling edge where outputs are steady.
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  // One write: address and data offered together, each released once taken.
  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] st, input logic [1:0] er);
    bit ad, dd, bd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bd) begin
      @(negedge aclk);
      ad = s_axi_awvalid && s_axi_awready;
      dd = s_axi_wvalid && s_axi_wready;
      bd = s_axi_bvalid;
      if (bd) chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      @(posedge aclk);
      if (ad) s_axi_awvalid <= 1'b0;
      if (dd) s_axi_wvalid <= 1'b0;
      if (bd) s_axi_bready <= 1'b0;
    end
  endtask
  // One read: ready is raised a cycle late so the slave must hold its answer.
  task automatic axi_rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    bit at, rv, rd = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!rd) begin
      @(negedge aclk);
      at = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      rd = rv && s_axi_rready;
      if (rd) chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      if (rd) chk("rdata", {24'h0, d}, s_axi_rdata);
      @(posedge aclk);
      if (at) s_axi_arvalid <= 1'b0;
      if (rd) s_axi_rready <= 1'b0;
      else if (rv) s_axi_rready <= 1'b1;
    end
  endtask
  // Cleared state straight after reset.
  task automatic t_reset;
    settle(0);
    chk("oe_n", 8'hff, pin_oe_n);
    chk("out", 8'h00, pin_out);
    axi_rd(4'h4, 8'h00, 2'h0);
    axi_rd(4'h0, 8'h00, 2'h0);
    $display("test reset done");
  endtask
  // Direction, data and pin state over all eight bits, both ways round.
  task automatic t_gpio;
    ext_level <= 8'h3c;
    axi_wr(4'h4, 8'ha5, 4'hf, 2'h0);
    axi_wr(4'h0, 8'h0f, 4'hf, 2'h0);
    settle(8);
    chk("oe_n", 8'hf0, pin_oe_n);
    chk("out", 8'h05, {4'h0, pin_out[3:0]});
    axi_rd(4'h4, 8'ha5, 2'h0);
    axi_rd(4'h0, 8'h00, 2'h0);
    axi_rd(4'h8, 8'h35, 2'h0);
    axi_wr(4'h0, 8'hf0, 4'hf, 2'h0);
    settle(8);
    chk("oe_n", 8'h0f, pin_oe_n);
    axi_rd(4'h8, 8'hac, 2'h0);
    $display("test gpio done");
  endtask
  // Read-only state, strobe-less write and the unmapped word.
  task automatic t_ro;
    axi_wr(4'h8, 8'h00, 4'hf, 2'h0);
    axi_wr(4'h4, 8'h00, 4'h0, 2'h0);
    axi_wr(4'hc, 8'h00, 4'hf, 2'h2);
    axi_rd(4'hc, 8'h00, 2'h2);
    axi_rd(4'h8, 8'hac, 2'h0);
    chk("out", 8'ha0, {pin_out[7:4], 4'h0});
    $display("test read-only done");
  endtask
  // Timer drive wins over the direction bit and blocks the pin inputs.
  task automatic t_timer;
    cfg <= {7'h0b, 16'h0};
    tmr_pin_oe <= 3'h7;
    tmr_pin_out <= 3'h2;
    settle(8);
    chk("out75", 8'h02, {5'h0, pin_out[7:5]});
    chk("tin", 8'h00, {2'h0, tin});
    axi_wr(4'h0, 8'h00, 4'hf, 2'h0);
    settle(1);
    chk("oe_n", 8'h1f, pin_oe_n);
    @(posedge aclk);
    tmr_pin_oe <= 3'h0;
    $display("test timer drive done");
  endtask
  // Every select combination of the mux table with pins 7..5 held high as inputs.
  task automatic t_mux;
    ext_level <= 8'he0;
    for (i = 0; i < 16; i++) begin
      @(posedge aclk);
      cfg <= tbl[i][28:6];
      settle(8);
      chk("tin", {26'h0, tbl[i][5:0]}, {26'h0, tin});
    end
    $display("test pin mux done");
  endtask
  // Free-running clock.
  initial begin
    forever #20 aclk = ~aclk;
  end
  // Cuts a hang short well past the expected run length.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      report_and_stop();
    end
  end
  // Main sequence.
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_gpio();
    t_ro();
    t_timer();
    t_mux();
    report_and_stop();
  end
endmodule
